// *** rtl/idb_bridge.sv ***
// ISA data bridge and backplane cycle sequencer
`timescale 1ns/100ps
module idb_bridge #(
  parameter int DEPTH = 2
) (
  // Clock, reset, enable
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        CE,
  // Host bus cycle
  input  wire logic        HOST_ADDRESS_STROBE_N,
  input  wire logic        HOST_MEM_IO,
  input  wire logic        HOST_WRITE,
  input  wire logic        LOCAL_CLAIM_N,
  input  wire logic        HOST_READY_IN_N,
  output logic             HOST_READY_OUT_N,
  output logic             NARROW_BUS_SIZE_REQUEST_N,
  output logic             NEXT_ADDRESS_PIPELINE_REQUEST_N,
  output logic             NEXT_ADDRESS_PIPELINE_REQUEST_OE,
  // Host byte enables, two-way
  input  wire logic [3:0]  HOST_BYTE_ENABLE_N_IN,
  output logic      [3:0]  HOST_BYTE_ENABLE_N_OUT,
  output logic             HOST_BYTE_ENABLE_OE,
  // Host data, two-way
  input  wire logic [15:0] HOST_DATA_IN,
  output logic      [15:0] HOST_DATA_OUT,
  output logic             HOST_DATA_OE,
  // Backplane moderators
  input  wire logic        BCLK,
  input  wire logic        MEM_CS16_N,
  input  wire logic        IO_CS16_N,
  input  wire logic        CHANNEL_READY,
  input  wire logic        ZERO_WAIT_N,
  // Backplane data, two-way
  input  wire logic [15:0] SD_IN,
  output logic      [15:0] SD_OUT,
  output logic             SD_OE,
  // Backplane low address, two-way
  input  wire logic [1:0]  BP_ADDR_LOW_IN,
  input  wire logic        LATCHED_BYTE_HIGH_ENABLE_N,
  output logic      [1:0]  BP_ADDR_LOW_OUT,
  output logic             BP_ADDR_LOW_OE,
  // Backplane control
  output logic             ADDRESS_LATCH_ENABLE,
  output logic      [3:0]  BP_CMD_N,
  output logic             BP_CMD_OE,
  // Mode and default length
  input  wire logic        DMA_MODE,
  input  wire logic [2:0]  DEFAULT_CYCLE_BCLKS
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    idb_pkg::idb_state_t          st;
    logic [1:0]                   claim_cnt;
    logic [idb_pkg::SY_W-1:0]     s1;
    logic [idb_pkg::SY_W-1:0]     s2;
    logic [idb_pkg::SY_W-1:0]     s3;
    logic [idb_pkg::SY_W-1:0]     filt;
    logic [5:0]                   ph;
    logic                         mem;
    logic                         wr;
    logic                         upper;
    logic                         be_lo;
    logic                         be_hi;
    logic                         second;
    logic                         is16;
    logic                         narrow_bus_size_request_n;
    logic                         na;
    logic [15:0]                  wdata;
    logic [15:0]                  sd_out;
    logic                         sd_oe;
    logic [7:0]                   rd_lo;
    logic [15:0]                  rdata;
    logic                         bale;
    logic                         cmd_on;
    logic [1:0]                   sa;
    logic [3:0]                   dma_be_n;
    logic [DEPTH-1:0][15:0]       bdata;
    logic [PW-1:0]                wp;
    logic [PW-1:0]                rp;
    logic [PW:0]                  cnt;
  } idb_regs_t;

  idb_regs_t q;
  idb_regs_t n;

  // One-hot command for the cycle type
  function automatic logic [3:0] cmd_sel(input logic mem, input logic wr);
    logic [3:0] c;
    c = 4'h0;
    if (mem)
      c[wr ? idb_pkg::CMD_MEMW : idb_pkg::CMD_MEMR] = 1'b1;
    else
      c[wr ? idb_pkg::CMD_IOW : idb_pkg::CMD_IOR] = 1'b1;
    return c;
  endfunction : cmd_sel

  // Byte lanes from low address and high enable; one half only
  function automatic logic [3:0] dma_be(input logic [1:0] a, input logic bhe_n);
    logic [1:0] pair;
    pair = {a[0] | ~bhe_n, ~a[0]};
    return ~(a[1] ? {pair, 2'h0} : {2'h0, pair});
  endfunction : dma_be

  always_comb
  begin
    logic       edge_b;
    logic       rise_b;
    logic       push;
    logic       pop;
    logic       done;
    logic       lo_any;
    logic [2:0] len;
    logic [5:0] ph_nx;
    edge_b = 1'b0;
    rise_b = 1'b0;
    push   = 1'b0;
    pop    = 1'b0;
    done   = 1'b0;
    lo_any = 1'b0;
    len    = DEFAULT_CYCLE_BCLKS;
    ph_nx  = 6'h00;
    n      = q;

    // Pins pass three flops; a level counts once stages two and three agree
    n.s1   = {ZERO_WAIT_N, CHANNEL_READY, IO_CS16_N, MEM_CS16_N, BCLK};
    n.s2   = q.s1;
    n.s3   = q.s2;
    n.filt = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.filt);
    edge_b = n.filt[idb_pkg::SY_BCLK] ^ q.filt[idb_pkg::SY_BCLK];
    rise_b = edge_b & n.filt[idb_pkg::SY_BCLK];

    // Out-of-range settings are clamped rather than trusted
    if (len < idb_pkg::LEN_MIN)
      len = idb_pkg::LEN_MIN;
    else if (len > idb_pkg::LEN_MAX)
      len = idb_pkg::LEN_MAX;

    n.dma_be_n = dma_be(BP_ADDR_LOW_IN, LATCHED_BYTE_HIGH_ENABLE_N);

    pop = (q.cnt != '0) && !HOST_READY_IN_N;

    unique case (q.st)
      idb_pkg::ST_IDLE:
      begin
        if (!DMA_MODE && !HOST_ADDRESS_STROBE_N)
        begin
          lo_any      = ~&HOST_BYTE_ENABLE_N_IN[1:0];
          n.st        = idb_pkg::ST_CLAIM;
          n.claim_cnt = 2'h1;
          n.mem       = HOST_MEM_IO;
          n.wr        = HOST_WRITE;
          n.upper     = ~&HOST_BYTE_ENABLE_N_IN[3:2];
          n.be_lo     = lo_any ? ~HOST_BYTE_ENABLE_N_IN[0] : ~HOST_BYTE_ENABLE_N_IN[2];
          n.be_hi     = lo_any ? ~HOST_BYTE_ENABLE_N_IN[1] : ~HOST_BYTE_ENABLE_N_IN[3];
          n.sa[1]     = ~lo_any;
          n.second    = 1'b0;
        end
      end
      idb_pkg::ST_CLAIM:
      begin
        n.claim_cnt = q.claim_cnt + 2'h1;
        if (q.claim_cnt == idb_pkg::CLAIM_DELAY)
        begin
          if (!LOCAL_CLAIM_N)
            n.st = idb_pkg::ST_IDLE;
          else
          begin
            n.st    = idb_pkg::ST_SYNC;
            n.narrow_bus_size_request_n  = q.upper;
            n.na    = ~q.upper;
            n.wdata = HOST_DATA_IN;
            n.sa[0] = ~q.be_lo;
            // Single high byte goes on both lanes, suiting either width
            n.sd_out = q.be_lo ? HOST_DATA_IN : {2{HOST_DATA_IN[15:8]}};
            n.sd_oe  = q.wr;
          end
        end
      end
      idb_pkg::ST_SYNC:
      begin
        // Rising edge marks half a clock before latch enable
        if (rise_b)
        begin
          n.st = idb_pkg::ST_CMD;
          n.ph = 6'h00;
        end
      end
      idb_pkg::ST_CMD:
      begin
        if (edge_b)
        begin
          ph_nx  = (q.ph == idb_pkg::PH_SAT) ? q.ph : q.ph + 6'h01;
          n.ph   = ph_nx;
          n.bale = (ph_nx == idb_pkg::PH_ALE);
          if (ph_nx == idb_pkg::PH_CMD)
          begin
            n.is16 = q.mem ? ~n.filt[idb_pkg::SY_MCS16] : ~n.filt[idb_pkg::SY_IOCS16];
            n.cmd_on = 1'b1;
          end
          if (q.ph >= idb_pkg::PH_CMD)
          begin
            // Ready low stretches; zero-wait may cut to the minimum
            done = (ph_nx >= {2'h0, len, 1'b0} && q.filt[idb_pkg::SY_CHRDY]) ||
                   (ph_nx >= {2'h0, idb_pkg::LEN_MIN, 1'b0} &&
                    !q.filt[idb_pkg::SY_ZWS]);
          end
          if (done)
          begin
            n.cmd_on = 1'b0;
            if (q.second)
              n.rdata = {SD_IN[7:0], q.rd_lo};
            else if (q.is16)
              n.rdata = SD_IN;
            else
              n.rdata = {2{SD_IN[7:0]}};
            if (!q.second && !q.is16 && q.be_lo && q.be_hi)
            begin
              n.st     = idb_pkg::ST_SYNC;
              n.second = 1'b1;
              n.rd_lo  = SD_IN[7:0];
              n.sa[0]  = 1'b1;
              n.sd_out = {2{q.wdata[15:8]}};
            end
            else
              n.st = idb_pkg::ST_DONE;
          end
        end
      end
      idb_pkg::ST_DONE:
      begin
        n.sd_oe = 1'b0;
        // Stall here while the buffer is full
        if (q.cnt != DEPTH[PW:0])
        begin
          push = 1'b1;
          n.st = idb_pkg::ST_WAIT;
        end
      end
      idb_pkg::ST_WAIT:
      begin
        if (pop)
        begin
          n.st     = idb_pkg::ST_IDLE;
          n.narrow_bus_size_request_n   = 1'b0;
          n.na     = 1'b0;
          n.second = 1'b0;
        end
      end
      default:
        n.st = idb_pkg::ST_IDLE;
    endcase

    if (push)
    begin
      n.bdata[q.wp] = q.rdata;
      n.wp          = (q.wp == PW'(DEPTH - 1)) ? '0 : q.wp + PW'(1);
    end
    if (pop)
      n.rp = (q.rp == PW'(DEPTH - 1)) ? '0 : q.rp + PW'(1);
    if (push && !pop)
      n.cnt = q.cnt + (PW+1)'(1);
    else if (pop && !push)
      n.cnt = q.cnt - (PW+1)'(1);
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      q <= '0;
    else if (CE)
      q <= n;
  end

  assign HOST_READY_OUT_N                 = (q.cnt == '0);
  assign HOST_DATA_OUT                    = q.bdata[q.rp];
  assign HOST_DATA_OE                     = (q.cnt != '0) && !q.wr;
  assign NARROW_BUS_SIZE_REQUEST_N        = ~q.narrow_bus_size_request_n;
  assign NEXT_ADDRESS_PIPELINE_REQUEST_N  = ~q.na;
  assign NEXT_ADDRESS_PIPELINE_REQUEST_OE = q.na;
  assign HOST_BYTE_ENABLE_N_OUT           = q.dma_be_n;
  assign HOST_BYTE_ENABLE_OE              = DMA_MODE;
  assign SD_OUT                           = q.sd_out;
  assign SD_OE                            = q.sd_oe && !DMA_MODE;
  assign BP_ADDR_LOW_OUT                  = q.sa;
  assign BP_ADDR_LOW_OE                   = !DMA_MODE;
  // Master owns commands; latch enable open for address flow-through
  assign ADDRESS_LATCH_ENABLE             = DMA_MODE | q.bale;
  assign BP_CMD_N                         = ~(q.cmd_on ? cmd_sel(q.mem, q.wr) : 4'h0);
  assign BP_CMD_OE                        = !DMA_MODE;

endmodule : idb_bridge

// *** rtl/idb_pkg.sv ***
// Shared constants and types for the ISA data bridge and cycle sequencer
package idb_pkg;

  // Host clock rate, double-rate clock in MHz
  localparam int         CLK_MHZ     = 100;
  // Host clocks from strobe sample to claim sample
  localparam logic [1:0] CLAIM_DELAY = 2'h2;

  // Backplane cycle length in BCLK cycles: default, and clamp limits for the input
  localparam logic [2:0] LEN_RESET   = 3'h6;
  localparam logic [2:0] LEN_MIN     = 3'h3;
  localparam logic [2:0] LEN_MAX     = 3'h6;

  // Half-BCLK phase where address latch enable is high
  localparam logic [5:0] PH_ALE      = 6'h01;
  // First half-BCLK phase of the command
  localparam logic [5:0] PH_CMD      = 6'h02;
  localparam logic [5:0] PH_SAT      = 6'h3F;

  // Bit positions in the synchronised backplane input vector
  localparam int         SY_BCLK     = 0;
  localparam int         SY_MCS16    = 1;
  localparam int         SY_IOCS16   = 2;
  localparam int         SY_CHRDY    = 3;
  localparam int         SY_ZWS      = 4;
  localparam int         SY_W        = 5;

  // Command bit positions, active high internally
  localparam int         CMD_IOR     = 0;
  localparam int         CMD_IOW     = 1;
  localparam int         CMD_MEMR    = 2;
  localparam int         CMD_MEMW    = 3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CLAIM,
    ST_SYNC,
    ST_CMD,
    ST_DONE,
    ST_WAIT
  } idb_state_t;

endpackage : idb_pkg

// *** tb/idb_bp_model.sv ***
// Behavioural backplane device: clock, width selects, wait states, data
`timescale 1ns/100ps
module idb_bp_model (
  // Bench side
  input  wire logic        clk,
  input  wire logic        wide,
  input  wire logic        slow,
  input  wire logic        zws,
  input  wire logic [15:0] rdata,
  // Bridge side
  input  wire logic [3:0]  cmd_n,
  input  wire logic [15:0] sd_out,
  input  wire logic        sd_oe,
  input  wire logic        a0,
  output logic             bclk,
  output logic             cs16_n,
  output logic             chrdy,
  output logic             zws_n,
  output logic [15:0]      sd_in
);
  logic [15:0] wq[$];
  logic [15:0] last = 16'h0000;
  logic [15:0] cur  = 16'h0000;
  logic        wact = 1'b0;
  int          wcnt = 0;
  wire         rd   = !cmd_n[0] || !cmd_n[2];
  wire         wrc  = !cmd_n[1] || !cmd_n[3];
  // Free running, unrelated in phase to the host clock
  initial
  begin
    bclk = 1'b0;
    forever #61 bclk = ~bclk;
  end
  assign cs16_n = !wide;
  assign zws_n  = !zws;
  assign chrdy  = !(slow && cmd_n != 4'hF && wcnt < 2);
  // 8-bit part leaves the upper lanes to float
  assign sd_in = sd_oe ? sd_out : rd ? (wide ? rdata : {~rdata[15:8], a0 ? rdata[15:8] : rdata[7:0]}) : ~last;
  always @(posedge bclk) wcnt <= (cmd_n == 4'hF) ? 0 : wcnt + 1;
  always @(posedge clk)
  begin
    last <= sd_in;
    wact <= wrc;
    if (wrc) cur <= sd_out;
    else if (wact) wq.push_back(cur);
  end
endmodule : idb_bp_model

// *** tb/idb_bridge_asserts.sv ***
// Port checker for the ISA data bridge
`timescale 1ns/100ps
module idb_bridge_chk (
  // Clock and reset
  input wire logic       CLK,
  input wire logic       RST,
  // Watched ports
  input wire logic       DMA_MODE,
  input wire logic       HOST_READY_IN_N,
  input wire logic       HOST_READY_OUT_N,
  input wire logic       NARROW_BUS_SIZE_REQUEST_N,
  input wire logic       NEXT_ADDRESS_PIPELINE_REQUEST_N,
  input wire logic       NEXT_ADDRESS_PIPELINE_REQUEST_OE,
  input wire logic [3:0] HOST_BYTE_ENABLE_N_OUT,
  input wire logic       ADDRESS_LATCH_ENABLE,
  input wire logic [3:0] BP_CMD_N,
  input wire logic       BP_CMD_OE,
  input wire logic       SD_OE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  property p_pipe_oe; NEXT_ADDRESS_PIPELINE_REQUEST_OE == !NEXT_ADDRESS_PIPELINE_REQUEST_N; endproperty
  a_pipe_oe: assert property (p_pipe_oe) else $error("pipeline pin driven while idle");
  property p_excl; !(!NARROW_BUS_SIZE_REQUEST_N && !NEXT_ADDRESS_PIPELINE_REQUEST_N); endproperty
  a_excl: assert property (p_excl) else $error("size and pipeline requests together");
  property p_dma_ctl; DMA_MODE |-> ADDRESS_LATCH_ENABLE && !BP_CMD_OE; endproperty
  a_dma_ctl: assert property (p_dma_ctl) else $error("commands not released in DMA");
  property p_dma_sd; DMA_MODE |-> !SD_OE; endproperty
  a_dma_sd: assert property (p_dma_sd) else $error("backplane data driven in DMA");
  property p_dma_two; DMA_MODE && $past(DMA_MODE) |-> $countones(~HOST_BYTE_ENABLE_N_OUT) <= 2; endproperty
  a_dma_two: assert property (p_dma_two) else $error("more than two DMA bytes");
  property p_cmd_ale; !DMA_MODE && !$past(DMA_MODE) && $fell(ADDRESS_LATCH_ENABLE) |-> BP_CMD_N != 4'hF; endproperty
  a_cmd_ale: assert property (p_cmd_ale) else $error("no command after latch pulse");
  property p_one_cmd; !DMA_MODE |-> $countones(~BP_CMD_N) <= 1; endproperty
  a_one_cmd: assert property (p_one_cmd) else $error("two commands at once");
  property p_rdy_hold; !HOST_READY_OUT_N && HOST_READY_IN_N |=> !HOST_READY_OUT_N; endproperty
  a_rdy_hold: assert property (p_rdy_hold) else $error("ready dropped before return");
  c_ready: cover property ($fell(HOST_READY_OUT_N));
  c_narrow: cover property ($fell(NARROW_BUS_SIZE_REQUEST_N));
  c_dma: cover property (DMA_MODE && ADDRESS_LATCH_ENABLE);
endmodule : idb_bridge_chk

bind idb_bridge idb_bridge_chk u_chk (.CLK(CLK), .RST(RST), .DMA_MODE(DMA_MODE),
  .HOST_READY_IN_N(HOST_READY_IN_N), .HOST_READY_OUT_N(HOST_READY_OUT_N),
  .NARROW_BUS_SIZE_REQUEST_N(NARROW_BUS_SIZE_REQUEST_N),
  .NEXT_ADDRESS_PIPELINE_REQUEST_N(NEXT_ADDRESS_PIPELINE_REQUEST_N),
  .NEXT_ADDRESS_PIPELINE_REQUEST_OE(NEXT_ADDRESS_PIPELINE_REQUEST_OE),
  .HOST_BYTE_ENABLE_N_OUT(HOST_BYTE_ENABLE_N_OUT), .ADDRESS_LATCH_ENABLE(ADDRESS_LATCH_ENABLE),
  .BP_CMD_N(BP_CMD_N), .BP_CMD_OE(BP_CMD_OE), .SD_OE(SD_OE));

// *** tb/isa_data_bridge_cycle_ctrl_test.sv ***
// Self-checking bench for the ISA data bridge and cycle sequencer
`timescale 1ns/100ps
module isa_data_bridge_cycle_ctrl_test;
  logic        CLK = 0, RST = 1, ads_n = 1, mio = 0, wr = 0, claim_n = 1, rin_n = 1, dma = 0, lbhe_n = 1;
  logic        wide = 1, slow = 0, zws = 0, ce = 1;
  logic [3:0]  be_n = 4'hF;
  logic [1:0]  a_lo = 2'h0;
  logic [2:0]  len = 3'h6;
  logic [15:0] hd = 16'h0000, rdata = 16'h0000;
  logic [15:0] eq[$];
  logic [3:0]  bes[3] = '{4'hC, 4'h3, 4'hE};
  wire  [15:0] hd_o, sd_o, sd_i;
  wire  [3:0]  be_o, cmd_n;
  wire  [1:0]  a_o;
  wire         rout_n, size_n, pipe_n, bclk, cs16_n, chrdy, zws_n, sd_oe;
  int          err_count = 0, cmp_count = 0, cyc = 0, seed = 32'h03a8;
  idb_bridge DUT (.CLK(CLK), .RST(RST), .CE(ce), .HOST_ADDRESS_STROBE_N(ads_n), .HOST_MEM_IO(mio),
    .HOST_WRITE(wr), .LOCAL_CLAIM_N(claim_n), .HOST_READY_IN_N(rin_n), .HOST_READY_OUT_N(rout_n),
    .NARROW_BUS_SIZE_REQUEST_N(size_n), .NEXT_ADDRESS_PIPELINE_REQUEST_N(pipe_n),
    .NEXT_ADDRESS_PIPELINE_REQUEST_OE(), .HOST_BYTE_ENABLE_N_IN(be_n), .HOST_BYTE_ENABLE_N_OUT(be_o),
    .HOST_BYTE_ENABLE_OE(), .HOST_DATA_IN(hd), .HOST_DATA_OUT(hd_o), .HOST_DATA_OE(), .BCLK(bclk),
    .MEM_CS16_N(cs16_n), .IO_CS16_N(cs16_n), .CHANNEL_READY(chrdy), .ZERO_WAIT_N(zws_n), .SD_IN(sd_i),
    .SD_OUT(sd_o), .SD_OE(sd_oe), .BP_ADDR_LOW_IN(a_lo), .LATCHED_BYTE_HIGH_ENABLE_N(lbhe_n),
    .BP_ADDR_LOW_OUT(a_o), .BP_ADDR_LOW_OE(), .ADDRESS_LATCH_ENABLE(), .BP_CMD_N(cmd_n), .BP_CMD_OE(),
    .DMA_MODE(dma), .DEFAULT_CYCLE_BCLKS(len));
  idb_bp_model M (.clk(CLK), .wide(wide), .slow(slow), .zws(zws), .rdata(rdata), .cmd_n(cmd_n),
    .sd_out(sd_o), .sd_oe(sd_oe), .a0(a_o[0]), .bclk(bclk), .cs16_n(cs16_n), .chrdy(chrdy),
    .zws_n(zws_n), .sd_in(sd_i));
  always #5 CLK = ~CLK;
  task conclude;
    if (err_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  // Run is cut short well past the longest expected sequence
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      err_count++;
      conclude();
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic host(input logic w, input logic m, input logic [3:0] b, input logic own);
    logic [15:0] d, k, mk;
    int n;
    d = 16'($random(seed));
    k = (b == 4'hE) ? 16'h00FF : 16'hFFFF;
    hd <= d;
    rdata <= d;
    wr <= w;
    mio <= m;
    be_n <= b;
    claim_n <= own;
    slow <= 1'($random(seed));
    zws <= 1'($random(seed));
    len <= 3'h3 + 3'($random(seed) & 3);
    ads_n <= 1'b0;
    @(posedge CLK) ads_n <= 1'b1;
    repeat (2) @(posedge CLK);
    // Width select was set by the caller on the start edge, so read it only now
    mk = wide ? k : 16'h00FF;
    #1 chk(16'(size_n), 16'(!own || b[3:2] == 2'b11));
    chk(16'(pipe_n), 16'(!own || b[3:2] != 2'b11));
    if (!own)
    begin
      repeat (300) @(posedge CLK);
      #1 chk({rout_n, cmd_n, 11'(M.wq.size())}, 16'hF800);
      return;
    end
    if (w && !wide && k == 16'hFFFF) eq = '{{8'h00, d[7:0]}, {8'h00, d[15:8]}};
    else if (w) eq = '{d & mk};
    n = 0;
    while (rout_n !== 1'b0 && n < 3000)
    begin
      // Random enable gaps stretch the wait; all state must freeze
      @(posedge CLK) ce <= (($random(seed) & 7) != 0);
      #1 n++;
    end
    chk(16'(rout_n), 16'h0000);
    if (!w) chk(hd_o & k, d & k);
    chk(16'(M.wq.size()), 16'(eq.size()));
    while (eq.size() > 0 && M.wq.size() > 0) chk(M.wq.pop_front() & mk, eq.pop_front());
    eq.delete();
    @(posedge CLK) ce <= 1'b1;
    repeat ($random(seed) & 3) @(posedge CLK);
    @(posedge CLK) rin_n <= 1'b0;
    @(posedge CLK) rin_n <= 1'b1;
  endtask : host
  initial
  begin
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    repeat (4) @(posedge CLK);
    for (int i = 0; i < 24; i++)
    begin
      wide <= i[2];
      host(i[0], i[1], bes[i / 8], 1'b1);
    end
    host(1'b1, 1'b0, 4'hC, 1'b0);
    @(posedge CLK) dma <= 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      @(posedge CLK) {a_lo, lbhe_n} <= k[2:0];
      // Byte lanes follow the low address and high enable in either half; strobes must be ignored here
      hd <= 16'($random(seed));
      ads_n <= k[0];
      repeat (3) @(posedge CLK);
      #1 chk(16'(be_o), 16'(4'(~((k[1] ? 4'h2 : (k[0] ? 4'h1 : 4'h3)) << (k[2] ? 2 : 0)))));
      chk(16'({rout_n, size_n, pipe_n, cmd_n}), 16'h007F);
    end
    @(posedge CLK) dma <= 1'b0;
    conclude();
  end
endmodule : isa_data_bridge_cycle_ctrl_test
